/* File: common/ddc_io_regs.vh */
// Constants of the sample input and output port logic.
// Assumes inclusion by bare name from the design files.
`ifndef DDC_IO_REGS_VH
`define DDC_IO_REGS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DDC_SAMPLE_W 14
`define DDC_WORD_W 16
`define DDC_PAIR_W 32
`define DDC_PAR_WORDS 8
`define DDC_SEL_W 3
`define DDC_DIAG_W 20

// ----------------------------------------
// Diagnostic bus bit positions
// ----------------------------------------
`define DDC_DIAG_SER_B 0
`define DDC_DIAG_SER_A 1
`define DDC_DIAG_FRAME 2
`define DDC_DIAG_READY 3
`define DDC_DIAG_PAR_LO 4
`define DDC_DIAG_PAR_HI 19

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define DDC_REF_CLK_HZ 20000000
`define DDC_READY_CYCLES 4
`define DDC_SYNC_MIN_CYCLES 4
`define DDC_SCK_HALF_CYCLES 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DDC_RST_SAMPLE 14'h0000
`define DDC_RST_WORD 16'h0000

`endif

/* File: verilog/ddc_sync2.v */
// Two flip-flop synchroniser of parameterised width.
// Assumes asynchronous inputs and one receiving clock.
`timescale 1ns/100ps
module ddc_sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Data
  input wire [W-1:0] d_in,
  output wire [W-1:0] q_out
);
  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      stab_q <= RST;
    end else begin
      meta_q <= d_in;
      stab_q <= meta_q;
    end
  end

  assign q_out = stab_q;
endmodule

/* File: verilog/ddc_ser_shift.v */
// Serial word shifter, most significant bit first.
// Assumes shift_en is a one-cycle launch-edge pulse on clk.
`timescale 1ns/100ps
module ddc_ser_shift #(
  parameter W = 32,
  parameter CW = 6
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire load,
  input wire [W-1:0] data,
  input wire shift_en,
  input wire abort,
  // Serial side
  output wire ser_bit,
  output wire busy,
  output wire [CW-1:0] bits_left
);
  localparam [CW-1:0] FULL = W[CW-1:0];

  reg [W-1:0] buf_q;
  reg [CW-1:0] cnt_q;
  reg bit_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= {W{1'b0}};
      cnt_q <= {CW{1'b0}};
      bit_q <= 1'b0;
    end else if (abort) begin
      buf_q <= {W{1'b0}};
      cnt_q <= {CW{1'b0}};
      bit_q <= 1'b0;
    end else if (load) begin
      buf_q <= data;
      cnt_q <= FULL;
    end else if (shift_en) begin
      if (cnt_q != {CW{1'b0}}) begin
        bit_q <= buf_q[W-1]; // see RQ1
        buf_q <= {buf_q[W-2:0], 1'b0};
        cnt_q <= cnt_q - 1'b1;
      end else begin
        bit_q <= 1'b0;
      end
    end
  end

  assign ser_bit = bit_q;
  assign busy = (cnt_q != {CW{1'b0}});
  assign bits_left = cnt_q;
endmodule

/* File: verilog/ddc_io_top.v */
// Sample capture and serial/parallel output ports of a two-channel downconverter.
// Assumes output words come from the filter datapath on ref_clk; sample, timebase, sync and parallel control pins are asynchronous.
`timescale 1ns/100ps
`include "ddc_io_regs.vh"

// Overview of operation
// RQ1: Serial words shift out MSB first, two's complement
// RQ2: Bits change on edge chosen by polarity
// RQ3: Serial pins undriven until drive enable set
// RQ4: Frame strobe per word or per pair
// RQ5: Diagnostic mode routes diagnostic bits to serial pins
// RQ6: Select picks one of eight parallel words
// RQ7: Parallel bus driven only while enable low; diagnostic mode drives it regardless of enable
// RQ8: Diagnostic mode puts diagnostic bits on parallel
// RQ9: Ready flag marks each output sample period
// RQ10: Ready always driven; diagnostic bit in diagnostic mode
// RQ11: Samples captured on rising timebase edge
// RQ12: Sync sampled on timebase edge, realigns counters
// RQ13: Sync discards held samples; high means unused
// RQ14: Reset returns every register to reset state
// RQ15: Sync held low at least four clocks
// RQ16: Ready flag lasts four system clocks
// RQ17: Parallel bus released while enable deasserted; diagnostic mode keeps it driven
module ddc_io_top #(
  parameter SAMPLE_W = `DDC_SAMPLE_W,
  parameter WORD_W = `DDC_WORD_W,
  parameter SCK_HALF = `DDC_SCK_HALF_CYCLES,
  parameter READY_CYCLES = `DDC_READY_CYCLES
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Sample inputs and timebase
  input wire master_timebase_input,
  input wire [SAMPLE_W-1:0] sample_in_chan_a,
  input wire [SAMPLE_W-1:0] sample_in_chan_b,
  input wire sync_input_n,
  // Captured samples towards the processing chain
  output wire [SAMPLE_W-1:0] captured_chan_a,
  output wire [SAMPLE_W-1:0] captured_chan_b,
  output wire captured_valid,
  output wire sync_realign,
  output wire chain_flush,
  // Output words from the filter datapath
  input wire out_word_valid,
  input wire [WORD_W-1:0] out_word_a_i,
  input wire [WORD_W-1:0] out_word_a_q,
  input wire [WORD_W-1:0] out_word_b_i,
  input wire [WORD_W-1:0] out_word_b_q,
  input wire [`DDC_PAR_WORDS*WORD_W-1:0] parallel_words,
  // Configuration
  input wire serial_drive_enable,
  input wire serial_edge_polarity,
  input wire iq_pair_framing,
  input wire frame_strobe_polarity,
  input wire ready_polarity,
  input wire diag_mode,
  input wire [`DDC_DIAG_W-1:0] diagnostic_bus,
  // Serial port
  output wire serial_out_chan_a,
  output wire serial_out_chan_a_oe,
  output wire serial_out_chan_b,
  output wire serial_out_chan_b_oe,
  output wire serial_bit_clk,
  output wire serial_bit_clk_oe,
  output wire serial_frame_strobe,
  output wire serial_frame_strobe_oe,
  // Parallel port
  input wire [`DDC_SEL_W-1:0] parallel_word_select,
  input wire parallel_drive_enable_n,
  output wire [WORD_W-1:0] parallel_word_bus,
  output wire parallel_word_bus_oe,
  // Ready flag
  output wire output_ready_flag
);
  localparam PAIR_W = 2 * WORD_W;
  localparam CW = 6;
  localparam [CW-1:0] PAIR_FULL = PAIR_W[CW-1:0];
  localparam [CW-1:0] PAIR_HALF = WORD_W[CW-1:0];
  localparam [7:0] HALF_MAX = SCK_HALF[7:0] - 8'h01;
  localparam [3:0] READY_MAX = READY_CYCLES[3:0] - 4'h1;
  localparam IN_W = 2 * SAMPLE_W + 2;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [IN_W-1:0] pin_s;
  wire [`DDC_SEL_W+1-1:0] par_ctl_s;
  wire tb_s;
  wire sync_n_s;
  wire [SAMPLE_W-1:0] smp_a_s;
  wire [SAMPLE_W-1:0] smp_b_s;
  wire [`DDC_SEL_W-1:0] sel_s;
  wire par_en_n_s;

  ddc_sync2 #(
    .W(IN_W),
    .RST({{(2*SAMPLE_W){1'b0}}, 2'b10})
  ) u_sync_in (
    .clk(ref_clk),
    .rst_n(reset_n),
    .d_in({sample_in_chan_a, sample_in_chan_b, sync_input_n, master_timebase_input}),
    .q_out(pin_s)
  );

  ddc_sync2 #(
    .W(`DDC_SEL_W + 1),
    .RST({{`DDC_SEL_W{1'b0}}, 1'b1})
  ) u_sync_par (
    .clk(ref_clk),
    .rst_n(reset_n),
    .d_in({parallel_word_select, parallel_drive_enable_n}),
    .q_out(par_ctl_s)
  );

  assign tb_s = pin_s[0];
  assign sync_n_s = pin_s[1];
  assign smp_b_s = pin_s[SAMPLE_W+1:2];
  assign smp_a_s = pin_s[2*SAMPLE_W+1:SAMPLE_W+2];
  assign par_en_n_s = par_ctl_s[0];
  assign sel_s = par_ctl_s[`DDC_SEL_W:1];

  // ----------------------------------------
  // Sample capture and sync
  // ----------------------------------------
  reg tb_prev_q;
  reg [SAMPLE_W-1:0] cap_a_q;
  reg [SAMPLE_W-1:0] cap_b_q;
  reg cap_valid_q;
  reg sync_act_q;
  reg realign_q;
  wire tb_rise;

  assign tb_rise = tb_s & ~tb_prev_q;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin // see RQ14
      tb_prev_q <= 1'b0;
      cap_a_q <= `DDC_RST_SAMPLE;
      cap_b_q <= `DDC_RST_SAMPLE;
      cap_valid_q <= 1'b0;
      sync_act_q <= 1'b0;
      realign_q <= 1'b0;
    end else begin
      tb_prev_q <= tb_s;
      cap_valid_q <= 1'b0;
      realign_q <= 1'b0;
      if (tb_rise) begin
        sync_act_q <= ~sync_n_s; // see RQ12
        realign_q <= ~sync_n_s & ~sync_act_q; // see RQ12
        if (!sync_n_s) begin
          cap_a_q <= `DDC_RST_SAMPLE; // see RQ13
          cap_b_q <= `DDC_RST_SAMPLE; // see RQ13
        end else begin
          cap_a_q <= smp_a_s; // see RQ11
          cap_b_q <= smp_b_s; // see RQ11
          cap_valid_q <= 1'b1;
        end
      end
    end
  end

  assign captured_chan_a = cap_a_q;
  assign captured_chan_b = cap_b_q;
  assign captured_valid = cap_valid_q;
  assign sync_realign = realign_q;
  assign chain_flush = sync_act_q;

  // ----------------------------------------
  // Ready flag
  // ----------------------------------------
  reg [3:0] rdy_cnt_q;
  reg rdy_act_q;
  reg rdy_pin_q;
  wire start_osp;

  assign start_osp = out_word_valid & ~sync_act_q;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_cnt_q <= 4'h0;
      rdy_act_q <= 1'b0;
      rdy_pin_q <= 1'b0;
    end else begin
      if (sync_act_q) begin
        rdy_act_q <= 1'b0;
        rdy_cnt_q <= 4'h0;
      end else if (start_osp) begin
        rdy_act_q <= 1'b1; // see RQ9
        rdy_cnt_q <= READY_MAX; // see RQ16
      end else if (rdy_cnt_q != 4'h0) begin
        rdy_cnt_q <= rdy_cnt_q - 4'h1;
      end else begin
        rdy_act_q <= 1'b0;
      end
      if (diag_mode) begin
        rdy_pin_q <= diagnostic_bus[`DDC_DIAG_READY]; // see RQ10
      end else begin
        rdy_pin_q <= (start_osp | (rdy_act_q & rdy_cnt_q != 4'h0)) ^ ready_polarity; // see RQ9
      end
    end
  end

  assign output_ready_flag = rdy_pin_q; // see RQ10

  // ----------------------------------------
  // Bit clock divider
  // ----------------------------------------
  reg [7:0] div_q;
  reg sck_q;
  wire half_tick;
  wire launch;

  assign half_tick = (div_q == HALF_MAX);
  assign launch = half_tick & (sck_q == serial_edge_polarity); // see RQ2

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 8'h00;
      sck_q <= 1'b0;
    end else if (half_tick) begin
      div_q <= 8'h00;
      sck_q <= ~sck_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // Serial shifters
  // ----------------------------------------
  wire bit_a;
  wire bit_b;
  wire busy_a;
  wire [CW-1:0] left_a;

  ddc_ser_shift #(
    .W(PAIR_W),
    .CW(CW)
  ) u_shift_a (
    .clk(ref_clk),
    .rst_n(reset_n),
    .load(start_osp),
    .data({out_word_a_i, out_word_a_q}),
    .shift_en(launch),
    .abort(sync_act_q),
    .ser_bit(bit_a),
    .busy(busy_a),
    .bits_left(left_a)
  );

  ddc_ser_shift #(
    .W(PAIR_W),
    .CW(CW)
  ) u_shift_b (
    .clk(ref_clk),
    .rst_n(reset_n),
    .load(start_osp),
    .data({out_word_b_i, out_word_b_q}),
    .shift_en(launch),
    .abort(sync_act_q),
    .ser_bit(bit_b),
    .busy(),
    .bits_left()
  );

  // ----------------------------------------
  // Frame strobe and serial pin mux
  // ----------------------------------------
  reg fs_q;
  reg diag_a_q;
  reg diag_b_q;
  reg diag_fs_q;
  reg ser_oe_q;
  wire word_start;

  assign word_start = busy_a & ((left_a == PAIR_FULL) | (~iq_pair_framing & left_a == PAIR_HALF));

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fs_q <= 1'b0;
      diag_a_q <= 1'b0;
      diag_b_q <= 1'b0;
      diag_fs_q <= 1'b0;
      ser_oe_q <= 1'b0; // see RQ3
    end else begin
      ser_oe_q <= serial_drive_enable; // see RQ3
      if (sync_act_q) begin
        fs_q <= 1'b0;
      end else if (launch) begin
        fs_q <= word_start; // see RQ4
      end
      if (launch) begin
        diag_a_q <= diagnostic_bus[`DDC_DIAG_SER_A]; // see RQ5
        diag_b_q <= diagnostic_bus[`DDC_DIAG_SER_B]; // see RQ5
        diag_fs_q <= diagnostic_bus[`DDC_DIAG_FRAME]; // see RQ5
      end
    end
  end

  assign serial_out_chan_a = diag_mode ? diag_a_q : bit_a; // see RQ5
  assign serial_out_chan_b = diag_mode ? diag_b_q : bit_b; // see RQ5
  assign serial_frame_strobe = diag_mode ? diag_fs_q : (fs_q ^ frame_strobe_polarity); // see RQ4
  assign serial_bit_clk = sck_q;
  assign serial_out_chan_a_oe = ser_oe_q;
  assign serial_out_chan_b_oe = ser_oe_q;
  assign serial_bit_clk_oe = ser_oe_q;
  assign serial_frame_strobe_oe = ser_oe_q;

  // ----------------------------------------
  // Parallel port
  // ----------------------------------------
  reg [WORD_W-1:0] par_q;
  reg par_oe_q;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      par_q <= `DDC_RST_WORD;
      par_oe_q <= 1'b0; // see RQ17
    end else if (diag_mode) begin
      par_q <= diagnostic_bus[`DDC_DIAG_PAR_HI:`DDC_DIAG_PAR_LO]; // see RQ8
      par_oe_q <= 1'b1; // see RQ8
    end else begin
      par_q <= parallel_words[sel_s*WORD_W +: WORD_W]; // see RQ6
      par_oe_q <= ~par_en_n_s; // see RQ7
    end
  end

  assign parallel_word_bus = par_q;
  assign parallel_word_bus_oe = par_oe_q; // see RQ17
endmodule

/* File: test/ddc_io_monitor.sv */
// Checker of the capture and output port block.
// Assumes binding to ddc_io_top; sees its ports only.
`timescale 1ns/100ps
module ddc_io_monitor #(
  parameter WORD_W = 16,
  parameter READY_CYCLES = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset_n,
  // Control and configuration
  input wire out_word_valid,
  input wire chain_flush,
  input wire sync_realign,
  input wire captured_valid,
  input wire diag_mode,
  input wire ready_polarity,
  input wire frame_strobe_polarity,
  input wire serial_drive_enable,
  input wire serial_edge_polarity,
  input wire [19:0] diagnostic_bus,
  // Serial port
  input wire serial_out_chan_a,
  input wire serial_out_chan_b,
  input wire serial_frame_strobe,
  input wire serial_bit_clk,
  input wire serial_out_chan_a_oe,
  input wire serial_out_chan_b_oe,
  input wire serial_bit_clk_oe,
  input wire serial_frame_strobe_oe,
  // Parallel port and ready flag
  input wire [2:0] parallel_word_select,
  input wire parallel_drive_enable_n,
  input wire parallel_word_bus_oe,
  input wire output_ready_flag,
  input wire [8*WORD_W-1:0] parallel_words,
  input wire [WORD_W-1:0] parallel_word_bus
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ready_len_a:
    assert property (out_word_valid && !chain_flush && !diag_mode |->
      ##1 (output_ready_flag ^ ready_polarity)[*4] ##1 !(output_ready_flag ^ ready_polarity)) else $error("ready length");
  serial_off_a:
    assert property (!$past(serial_drive_enable) |-> !(serial_out_chan_a_oe || serial_out_chan_b_oe ||
      serial_bit_clk_oe || serial_frame_strobe_oe)) else $error("serial driven");
  ready_diag_a:
    assert property (diag_mode && $past(diag_mode) && $past(reset_n) |->
      output_ready_flag == $past(diagnostic_bus[3])) else $error("diag ready");
  par_diag_a:
    assert property (diag_mode && $past(diag_mode) && $past(reset_n) |->
      parallel_word_bus_oe && parallel_word_bus == $past(diagnostic_bus[19:4])) else $error("diag parallel");
  par_word_a:
    assert property ((reset_n && !parallel_drive_enable_n && !diag_mode && $stable(parallel_word_select)
      && $stable(parallel_words))[*4] |-> parallel_word_bus_oe &&
      parallel_word_bus == parallel_words[parallel_word_select*WORD_W +: WORD_W]) else $error("parallel word");
  par_off_a:
    assert property ((reset_n && parallel_drive_enable_n && !diag_mode)[*4] |-> !parallel_word_bus_oe)
      else $error("parallel not released");
  diag_ser_a:
    assert property ((reset_n && diag_mode && !frame_strobe_polarity && $stable(diagnostic_bus))[*8] |->
      serial_out_chan_a == diagnostic_bus[1] && serial_out_chan_b == diagnostic_bus[0] &&
      serial_frame_strobe == diagnostic_bus[2]) else $error("diag serial");
  bit_edge_a:
    assert property ($changed(serial_out_chan_a) && $past(reset_n) && !diag_mode && !$past(diag_mode)
      && !chain_flush && !$past(chain_flush) |-> $changed(serial_bit_clk) &&
      serial_bit_clk != $past(serial_edge_polarity)) else $error("bit edge");
  flush_capture_a:
    assert property (chain_flush |-> !captured_valid) else $error("capture in flush");
  realign_flush_a:
    assert property (sync_realign |-> chain_flush) else $error("realign alone");
  cover property (sync_realign);
  cover property (diag_mode && parallel_word_bus_oe);
  cover property (out_word_valid && serial_drive_enable);
endmodule

bind ddc_io_top ddc_io_monitor #(.WORD_W(WORD_W), .READY_CYCLES(READY_CYCLES)) mon (
  .ref_clk(ref_clk), .reset_n(reset_n), .out_word_valid(out_word_valid), .chain_flush(chain_flush),
  .sync_realign(sync_realign), .captured_valid(captured_valid), .diag_mode(diag_mode),
  .ready_polarity(ready_polarity), .frame_strobe_polarity(frame_strobe_polarity),
  .serial_drive_enable(serial_drive_enable), .serial_edge_polarity(serial_edge_polarity),
  .diagnostic_bus(diagnostic_bus), .serial_out_chan_a(serial_out_chan_a), .serial_out_chan_b(serial_out_chan_b),
  .serial_frame_strobe(serial_frame_strobe), .serial_bit_clk(serial_bit_clk),
  .serial_out_chan_a_oe(serial_out_chan_a_oe), .serial_out_chan_b_oe(serial_out_chan_b_oe),
  .serial_bit_clk_oe(serial_bit_clk_oe), .serial_frame_strobe_oe(serial_frame_strobe_oe),
  .parallel_word_select(parallel_word_select), .parallel_drive_enable_n(parallel_drive_enable_n),
  .parallel_word_bus_oe(parallel_word_bus_oe), .output_ready_flag(output_ready_flag),
  .parallel_words(parallel_words), .parallel_word_bus(parallel_word_bus)
);

/* File: test/ddc_capture_model.sv */
// Serial capture model of the downstream processor.
// Assumes the serial pins of the block under test.
`timescale 1ns/100ps
module ddc_capture_model (
  // Serial pins and settings
  input wire sck,
  input wire data_a,
  input wire data_b,
  input wire frame,
  input wire edge_pol,
  input wire frame_pol,
  // Captured words
  output logic [31:0] word_a,
  output logic [31:0] word_b,
  output logic [31:0] frame_bits,
  output int words_done
);
  logic [31:0] sh_a, sh_b, sh_f;
  int nbits = 32;
  initial words_done = 0;
  // Sample on the edge opposite to launch
  always @(sck) begin
    if (sck === edge_pol) begin
      if ((frame ^ frame_pol) && nbits >= 32) nbits = 0;
      if (nbits < 32) begin
        sh_a = {sh_a[30:0], data_a};
        sh_b = {sh_b[30:0], data_b};
        sh_f = {sh_f[30:0], frame ^ frame_pol};
        nbits++;
        if (nbits == 32) begin
          {word_a, word_b, frame_bits} = {sh_a, sh_b, sh_f};
          words_done++;
        end
      end
    end
  end
endmodule

/* File: test/ddc_sample_io_ports_tb.sv */
// Self-checking bench of the capture and output port block.
// Assumes ddc_io_top, its checker and the capture model.
`timescale 1ns/100ps
module ddc_sample_io_ports_tb;
  logic ref_clk = 1'b0, reset_n = 1'b0, master_timebase_input = 1'b0, sync_input_n = 1'b1;
  logic out_word_valid = 1'b0, serial_drive_enable = 1'b0, serial_edge_polarity = 1'b0, iq_pair_framing = 1'b0;
  logic frame_strobe_polarity = 1'b0, ready_polarity = 1'b0, diag_mode = 1'b0, parallel_drive_enable_n = 1'b1;
  logic [13:0] sample_in_chan_a = 14'h0, sample_in_chan_b = 14'h0;
  logic [15:0] out_word_a_i = 16'h0, out_word_a_q = 16'h0, out_word_b_i = 16'h0, out_word_b_q = 16'h0;
  logic [127:0] parallel_words = 128'h0;
  logic [19:0] diagnostic_bus = 20'h0;
  logic [2:0] parallel_word_select = 3'h0;
  wire [13:0] captured_chan_a, captured_chan_b;
  wire [15:0] parallel_word_bus;
  wire captured_valid, sync_realign, chain_flush, serial_out_chan_a, serial_out_chan_a_oe, serial_out_chan_b;
  wire serial_out_chan_b_oe, serial_bit_clk, serial_bit_clk_oe, serial_frame_strobe, serial_frame_strobe_oe;
  wire parallel_word_bus_oe, output_ready_flag;
  logic [31:0] m_a, m_b, m_f;
  int m_done, failures = 0, checked = 0;

  ddc_io_top #(.SCK_HALF(2)) dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .master_timebase_input(master_timebase_input),
    .sample_in_chan_a(sample_in_chan_a), .sample_in_chan_b(sample_in_chan_b), .sync_input_n(sync_input_n),
    .captured_chan_a(captured_chan_a), .captured_chan_b(captured_chan_b), .captured_valid(captured_valid),
    .sync_realign(sync_realign), .chain_flush(chain_flush), .out_word_valid(out_word_valid),
    .out_word_a_i(out_word_a_i), .out_word_a_q(out_word_a_q), .out_word_b_i(out_word_b_i),
    .out_word_b_q(out_word_b_q), .parallel_words(parallel_words), .serial_drive_enable(serial_drive_enable),
    .serial_edge_polarity(serial_edge_polarity), .iq_pair_framing(iq_pair_framing),
    .frame_strobe_polarity(frame_strobe_polarity), .ready_polarity(ready_polarity), .diag_mode(diag_mode),
    .diagnostic_bus(diagnostic_bus), .serial_out_chan_a(serial_out_chan_a),
    .serial_out_chan_a_oe(serial_out_chan_a_oe), .serial_out_chan_b(serial_out_chan_b),
    .serial_out_chan_b_oe(serial_out_chan_b_oe), .serial_bit_clk(serial_bit_clk),
    .serial_bit_clk_oe(serial_bit_clk_oe), .serial_frame_strobe(serial_frame_strobe),
    .serial_frame_strobe_oe(serial_frame_strobe_oe), .parallel_word_select(parallel_word_select),
    .parallel_drive_enable_n(parallel_drive_enable_n), .parallel_word_bus(parallel_word_bus),
    .parallel_word_bus_oe(parallel_word_bus_oe), .output_ready_flag(output_ready_flag)
  );
  ddc_capture_model dsp (.sck(serial_bit_clk), .data_a(serial_out_chan_a), .data_b(serial_out_chan_b),
    .frame(serial_frame_strobe), .edge_pol(serial_edge_polarity), .frame_pol(frame_strobe_polarity),
    .word_a(m_a), .word_b(m_b), .frame_bits(m_f), .words_done(m_done));

  always #25 ref_clk = ~ref_clk;
  initial begin
    #13;
    forever #200 master_timebase_input = ~master_timebase_input;
  end

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      failures++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic t_reset;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk(serial_out_chan_a_oe === 1'b0 && serial_bit_clk_oe === 1'b0 && parallel_word_bus_oe === 1'b0, "oe");
    chk(output_ready_flag === 1'b0 && captured_valid === 1'b0 && captured_chan_a === 14'h0, "reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic t_serial(input logic [4:0] cfg, input logic [63:0] w);
    int n0;
    int i;
    @(posedge ref_clk);
    {serial_drive_enable, serial_edge_polarity, iq_pair_framing, frame_strobe_polarity, ready_polarity} <= cfg;
    repeat (4) @(posedge ref_clk);
    n0 = m_done;
    {out_word_a_i, out_word_a_q, out_word_b_i, out_word_b_q} <= w;
    out_word_valid <= 1'b1;
    @(posedge ref_clk);
    out_word_valid <= 1'b0;
    for (i = 0; i < 5; i++) begin
      #1 chk((output_ready_flag ^ cfg[0]) === (i < 4), "ready pulse");
      @(posedge ref_clk);
    end
    for (i = 0; i < 400 && m_done == n0; i++) @(posedge ref_clk);
    if (cfg[4]) begin
      chk({m_a, m_b} === w, "serial words");
      chk(m_f === (cfg[2] ? 32'h8000_0000 : 32'h8000_8000), "frame strobe");
    end else
      chk(serial_out_chan_b_oe === 1'b0 && serial_frame_strobe_oe === 1'b0, "serial oe");
  endtask

  task automatic t_parallel;
    int k;
    @(posedge ref_clk);
    for (k = 0; k < 8; k++) parallel_words[k*16 +: 16] <= 16'hc3a0 ^ k[15:0];
    for (k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      parallel_word_select <= k[2:0];
      parallel_drive_enable_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1 chk(parallel_word_bus_oe === 1'b1 && parallel_word_bus === (16'hc3a0 ^ k[15:0]), "word");
    end
    @(posedge ref_clk);
    parallel_drive_enable_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk(parallel_word_bus_oe === 1'b0, "parallel released");
  endtask

  task automatic t_diag(input logic [19:0] d);
    @(posedge ref_clk);
    diag_mode <= 1'b1;
    diagnostic_bus <= d;
    repeat (10) @(posedge ref_clk);
    #1 chk({serial_out_chan_a, serial_out_chan_b, serial_frame_strobe} === {d[1], d[0], d[2]}, "diag");
    chk(output_ready_flag === d[3], "diag ready");
    chk(parallel_word_bus_oe === 1'b1 && parallel_word_bus === d[19:4], "diag parallel");
  endtask

  task automatic t_capture;
    int i;
    int nre = 0;
    int nv = 0;
    logic seen = 1'b0;
    @(posedge ref_clk);
    sample_in_chan_a <= 14'h2001;
    sample_in_chan_b <= 14'h1ffe;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk);
      #1 nv += (captured_valid === 1'b1);
    end
    chk(captured_chan_a === 14'h2001 && captured_chan_b === 14'h1ffe, "capture");
    chk(nv >= 7 && nv <= 8, "capture rate");
    for (i = 0; i < 70; i++) begin
      @(posedge ref_clk);
      sync_input_n <= (i >= 36);
      out_word_valid <= (i == 20);
      #1 nre += (sync_realign === 1'b1);
      seen |= (chain_flush === 1'b1);
      if (chain_flush === 1'b1) chk(captured_chan_a === 14'h0 && captured_valid === 1'b0, "flush");
      if (i > 20 && i < 26) chk(output_ready_flag === ready_polarity, "ready in flush");
    end
    chk(nre == 1 && seen, "sync realign");
    chk(captured_chan_a === 14'h2001, "capture after sync");
  endtask

  initial begin
    t_reset;
    t_serial(5'h00, 64'h8001_7ffe_0001_ffff);
    t_serial(5'h10, 64'h8001_7ffe_0001_ffff);
    t_serial(5'h17, 64'h1234_8765_fedc_0f0f);
    t_serial(5'h1a, 64'hc001_0003_7fff_8000);
    t_serial(5'h1c, 64'h5a5a_a5a5_0ff0_f00f);
    t_parallel;
    t_diag(20'ha_5c3a);
    t_diag(20'h5_3c45);
    @(posedge ref_clk);
    diag_mode <= 1'b0;
    t_reset;
    t_capture;
    report_and_stop;
  end

  initial begin
    #1_000_000;
    failures++;
    report_and_stop;
  end
endmodule
